// [core/self_test_controller.sv]
// Processor logic self-test controller: register slave, interval sequencer, timeout
// Functional notes
// - Whole run split into independent intervals, each run as its own unit.
// - Run either all intervals or a software-selected number of them.
// - New run resumes after last interval or restarts from first, as selected.
// - Core under test isolated from system while a run is active.
// - Number of failing interval captured and held for software.
// - Timeout counter loaded with programmed period bounds each run.
// - Self-test clock at most 45 MHz, divided from core clock by divider register.
// - Each interval lasts 1365 self-test clocks, up to 26 intervals.
// - Controller-issued processor reset recorded in exception status bit 5.
// - Core clock divided by 2 to 8 from the divider field during test (field plus one, raised to the minimum of 2).
module self_test_controller #(
    parameter int SIG_W = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire logic [st_pkg::ADDR_W-1:0] addr,
    input wire logic [st_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [st_pkg::DATA_W-1:0] rdata,
    // Signatures from the two lockstep cores
    input wire logic [SIG_W-1:0] core_a_sig,
    input wire logic [SIG_W-1:0] core_b_sig,
    // Test control towards the cores
    output logic core_isolate,
    output logic st_clk_en,
    output logic st_interval_start,
    output logic [st_pkg::COUNT_W-1:0] st_interval,
    output logic cpu_reset,
    // Interrupt
    output logic irq
);
    import st_pkg::*;

    // Effective division ratio, never faster than the self-test clock limit
    function automatic logic [3:0] eff_div(input logic [DIV_FIELD_W-1:0] field);
        logic [3:0] d;
        d = {1'b0, field} + 4'h1;
        if (int'(d) < MIN_DIV) begin
            d = 4'(MIN_DIV);
        end
        return d;
    endfunction

    // Sticky flag update: hardware set wins over a write-one clear
    function automatic logic [INT_W-1:0] w1c(input logic [INT_W-1:0] cur, input logic [INT_W-1:0] clr,
                                             input logic [INT_W-1:0] set);
        return (cur & ~clr) | set;
    endfunction

    state_t state_q;
    logic [COUNT_W-1:0] count_q;
    logic restart_q;
    logic [31:0] timeout_q;
    logic [DIV_FIELD_W-1:0] div_q;
    logic [INT_W-1:0] int_stat_q;
    logic [INT_W-1:0] int_mask_q;
    logic exc_reset_q;
    logic done_q;
    logic fail_q;
    logic tmo_q;
    logic [COUNT_W-1:0] fail_idx_q;
    logic [COUNT_W-1:0] next_q;
    logic [COUNT_W-1:0] cur_q;
    logic [COUNT_W-1:0] ran_q;
    logic [COUNT_W-1:0] target_q;
    logic [10:0] cyc_q;
    logic [3:0] div_cnt_q;
    logic [31:0] tmo_cnt_q;
    logic [3:0] rst_cnt_q;
    logic st_en;
    logic start_wr;
    logic iv_end;
    logic iv_fail;
    logic last_iv;
    logic tmo_hit;
    logic [INT_W-1:0] int_set;
    logic [INT_W-1:0] int_clr;
    logic [DATA_W-1:0] rdata_q;
    logic log_sel_q;
    logic log_hit;
    logic [COUNT_W-1:0] log_idx;
    logic [SIG_W-1:0] log_rdata;

    // Register write decode
    assign start_wr = wr_en && addr == CTRL_ADDR && wdata[CTRL_START_BIT] && state_q == S_IDLE;
    assign int_clr = (wr_en && addr == INT_STAT_ADDR) ? wdata[INT_W-1:0] : '0;

    // Configuration registers; start is a trigger and is not stored
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
            restart_q <= 1'b0;
            timeout_q <= TIMEOUT_RESET;
            div_q <= DIV_RESET;
            int_mask_q <= MASK_RESET;
        end else if (wr_en) begin
            case (addr)
                CTRL_ADDR: begin
                    count_q <= wdata[CTRL_COUNT_LSB +: COUNT_W];
                    restart_q <= wdata[CTRL_RESTART_BIT];
                end
                TIMEOUT_ADDR: timeout_q <= wdata;
                DIVIDER_FIELD_ADDR: div_q <= wdata[DIV_FIELD_LSB +: DIV_FIELD_W];
                INT_MASK_ADDR: int_mask_q <= wdata[INT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Self-test clock enable divider; only counts while running
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt_q <= '0;
        end else if (state_q != S_RUN) begin
            div_cnt_q <= '0;
        end else if (div_cnt_q >= eff_div(div_q) - 4'h1) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + 4'h1;
        end
    end

    // enable pulse at or below limit
    assign st_en = state_q == S_RUN && div_cnt_q >= eff_div(div_q) - 4'h1;
    assign st_clk_en = st_en;

    assign iv_end = st_en && int'(cyc_q) == INTERVAL_CYCLES - 1;
    assign iv_fail = iv_end && core_a_sig != core_b_sig;
    assign last_iv = ran_q + 5'h1 == target_q || int'(cur_q) == MAX_INTERVALS - 1;
    assign tmo_hit = state_q == S_RUN && tmo_cnt_q == '0 && !iv_end;

    // Cycle counter inside the current interval
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cyc_q <= '0;
        end else if (state_q != S_RUN || iv_end) begin
            cyc_q <= '0;
        end else if (st_en) begin
            cyc_q <= cyc_q + 11'h1;
        end
    end

    // Interval start marker for the test engine in the cores
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_interval_start <= 1'b0;
        end else begin
            st_interval_start <= start_wr || (iv_end && !iv_fail && !last_iv);
        end
    end

    // Timeout counter, reloaded at each start, in reference clock cycles
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tmo_cnt_q <= '0;
        end else if (start_wr) begin
            tmo_cnt_q <= timeout_q;
        end else if (state_q == S_RUN && tmo_cnt_q != '0) begin
            tmo_cnt_q <= tmo_cnt_q - 32'h1;
        end
    end

    // Run sequencer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
            rst_cnt_q <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start_wr) begin
                        state_q <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (tmo_hit || iv_fail || (iv_end && last_iv)) begin
                        state_q <= S_RESET;
                        rst_cnt_q <= '0;
                    end
                end
                S_RESET: begin
                    if (int'(rst_cnt_q) == CPU_RESET_CYCLES - 1) begin
                        state_q <= S_IDLE;
                    end else begin
                        rst_cnt_q <= rst_cnt_q + 4'h1;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Interval bookkeeping across runs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cur_q <= '0;
            next_q <= '0;
            ran_q <= '0;
            target_q <= 5'(MAX_INTERVALS);
        end else if (start_wr) begin
            cur_q <= wdata[CTRL_RESTART_BIT] ? '0 : next_q; // Starting write, not a stale copy
            ran_q <= '0;
            target_q <= wdata[CTRL_COUNT_LSB +: COUNT_W] == '0 ? 5'(MAX_INTERVALS) : wdata[CTRL_COUNT_LSB +: COUNT_W];
        end else if (iv_end) begin
            ran_q <= ran_q + 5'h1;
            if (int'(cur_q) == MAX_INTERVALS - 1) begin
                next_q <= '0;
            end else begin
                next_q <= cur_q + 5'h1;
            end
            if (!last_iv && !iv_fail) begin
                cur_q <= cur_q + 5'h1;
            end
        end
    end

    // Run result flags and failing interval number
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
            fail_q <= 1'b0;
            tmo_q <= 1'b0;
            fail_idx_q <= '0;
        end else if (start_wr) begin
            done_q <= 1'b0;
            fail_q <= 1'b0;
            tmo_q <= 1'b0;
        end else if (state_q == S_RUN) begin
            if (iv_fail) begin
                fail_q <= 1'b1;
                fail_idx_q <= cur_q;
            end
            if (tmo_hit) begin
                tmo_q <= 1'b1;
            end
            if (iv_end && last_iv) begin
                done_q <= 1'b1;
            end
        end
    end

    assign core_isolate = state_q != S_IDLE;
    assign st_interval = cur_q;
    assign cpu_reset = state_q == S_RESET;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            exc_reset_q <= 1'b0;
        end else if (state_q == S_RESET) begin
            exc_reset_q <= 1'b1;
        end else if (wr_en && addr == EXC_ADDR && wdata[EXC_CPU_RESET_BIT]) begin
            exc_reset_q <= 1'b0;
        end
    end

    // Interrupt events, one pulse each as the run ends
    always_comb begin
        int_set = '0;
        int_set[INT_DONE_BIT] = state_q == S_RUN && iv_end && last_iv && !iv_fail && !tmo_hit;
        int_set[INT_FAIL_BIT] = iv_fail;
        int_set[INT_TIMEOUT_BIT] = tmo_hit;
    end

    // Sticky interrupt status, write one to clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            int_stat_q <= '0;
        end else begin
            int_stat_q <= w1c(int_stat_q, int_clr, int_set);
        end
    end

    // Level interrupt, registered to keep the output glitch free
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(w1c(int_stat_q, int_clr, int_set) & int_mask_q);
        end
    end

    // Signature log window decode
    assign log_hit = addr >= LOG_BASE_ADDR && addr < LOG_BASE_ADDR + 32'(4 * MAX_INTERVALS);
    assign log_idx = 5'((addr - LOG_BASE_ADDR) >> 2);

    // Per-interval signature of the first core, kept for diagnosis
    sig_log_mem #(
        .WIDTH(SIG_W),
        .DEPTH(MAX_INTERVALS),
        .AW(COUNT_W)
    ) u_log (
        .clk(ref_clk),
        .wr_en(iv_end),
        .wr_addr(cur_q),
        .wr_data(core_a_sig),
        .rd_addr(log_idx),
        .rd_data(log_rdata)
    );

    // Register read, data valid in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
            log_sel_q <= 1'b0;
        end else begin
            rdata_q <= '0;
            log_sel_q <= rd_en && log_hit;
            if (rd_en) begin
                case (addr)
                    CTRL_ADDR: begin
                        rdata_q[CTRL_RESTART_BIT] <= restart_q;
                        rdata_q[CTRL_COUNT_LSB +: COUNT_W] <= count_q;
                    end
                    TIMEOUT_ADDR: rdata_q <= timeout_q;
                    DIVIDER_FIELD_ADDR: rdata_q[DIV_FIELD_LSB +: DIV_FIELD_W] <= div_q;
                    STATUS_ADDR: begin
                        rdata_q[ST_BUSY_BIT] <= state_q != S_IDLE;
                        rdata_q[ST_DONE_BIT] <= done_q;
                        rdata_q[ST_FAIL_BIT] <= fail_q;
                        rdata_q[ST_TIMEOUT_BIT] <= tmo_q;
                        rdata_q[ST_NEXT_LSB +: COUNT_W] <= next_q;
                        rdata_q[ST_CUR_LSB +: COUNT_W] <= cur_q;
                    end
                    FAIL_ADDR: rdata_q[COUNT_W-1:0] <= fail_idx_q;
                    EXC_ADDR: rdata_q[EXC_CPU_RESET_BIT] <= exc_reset_q;
                    INT_STAT_ADDR: rdata_q[INT_W-1:0] <= int_stat_q;
                    INT_MASK_ADDR: rdata_q[INT_W-1:0] <= int_mask_q;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Log words come straight from the memory's output register
    assign rdata = log_sel_q ? DATA_W'(log_rdata) : rdata_q;
endmodule

// [core/st_pkg.sv]
// Constants, register map and state type of the processor self-test controller
package st_pkg;
    // Bus geometry
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    // Register byte addresses
    localparam logic [31:0] CTRL_ADDR = 32'hFFFFE100;
    localparam logic [31:0] TIMEOUT_ADDR = 32'hFFFFE104;
    localparam logic [31:0] DIVIDER_FIELD_ADDR = 32'hFFFFE108;
    localparam logic [31:0] STATUS_ADDR = 32'hFFFFE10C;
    localparam logic [31:0] FAIL_ADDR = 32'hFFFFE110;
    localparam logic [31:0] EXC_ADDR = 32'hFFFFE114;
    localparam logic [31:0] INT_STAT_ADDR = 32'hFFFFE118;
    localparam logic [31:0] INT_MASK_ADDR = 32'hFFFFE11C;
    localparam logic [31:0] LOG_BASE_ADDR = 32'hFFFFE180;
    // Control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_RESTART_BIT = 1;
    localparam int CTRL_COUNT_LSB = 8;
    localparam int COUNT_W = 5;
    // Divider field of the self-test clock divider
    localparam int DIV_FIELD_LSB = 0;
    localparam int DIV_FIELD_W = 3;
    // Status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_FAIL_BIT = 2;
    localparam int ST_TIMEOUT_BIT = 3;
    localparam int ST_NEXT_LSB = 8;
    localparam int ST_CUR_LSB = 16;
    // Exception status: reset issued by the self-test controller
    localparam int EXC_CPU_RESET_BIT = 5;
    // Interrupt status and mask layout
    localparam int INT_DONE_BIT = 0;
    localparam int INT_FAIL_BIT = 1;
    localparam int INT_TIMEOUT_BIT = 2;
    localparam int INT_W = 3;
    // Reset values
    localparam logic [31:0] TIMEOUT_RESET = 32'h00010000;
    localparam logic [DIV_FIELD_W-1:0] DIV_RESET = 3'h0;
    localparam logic [INT_W-1:0] MASK_RESET = 3'h0;
    // Timing
    localparam longint REF_CLK_HZ = 50_000_000;
    localparam longint ST_CLK_MAX_HZ = 45_000_000;
    localparam int MIN_DIV = int'((REF_CLK_HZ + ST_CLK_MAX_HZ - 1) / ST_CLK_MAX_HZ);
    localparam int INTERVAL_CYCLES = 1365;
    localparam int MAX_INTERVALS = 26;
    localparam int CPU_RESET_CYCLES = 8;
    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_RUN = 3'b010,
        S_RESET = 3'b100
    } state_t;
endpackage

// [core/sig_log_mem.sv]
// Small memory holding the signature captured at the end of each test interval
module sig_log_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 26,
    parameter int AW = 5
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port, data one cycle later
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Write side; out of range indices are dropped
    always_ff @(posedge clk) begin
        if (wr_en && int'(wr_addr) < DEPTH) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read; unused indices read zero
    always_ff @(posedge clk) begin
        if (int'(rd_addr) < DEPTH) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end
endmodule

// [testbench/self_test_controller_props.sv]
// Port-level concurrent checks of the self-test controller
module self_test_controller_props
    import st_pkg::*;
#(
    parameter int SIG_W = 32
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [st_pkg::ADDR_W-1:0] addr,
    input wire logic [st_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [st_pkg::DATA_W-1:0] rdata,
    input wire logic [SIG_W-1:0] core_a_sig,
    input wire logic [SIG_W-1:0] core_b_sig,
    input wire logic core_isolate,
    input wire logic st_clk_en,
    input wire logic st_interval_start,
    input wire logic [st_pkg::COUNT_W-1:0] st_interval,
    input wire logic cpu_reset,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic [DIV_FIELD_W-1:0] div_q;
    logic [31:0] to_q;
    logic [31:0] run_q;
    logic [3:0] gap_q;
    logic prev_q;
    logic start_wr;
    int divide;
    assign start_wr = wr_en && addr == CTRL_ADDR && wdata[CTRL_START_BIT];
    assign divide = (int'(div_q) + 1 < MIN_DIV) ? MIN_DIV : int'(div_q) + 1;
    // Shadow of divider and timeout, since the checker sees only the bus
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= DIV_RESET;
            to_q <= TIMEOUT_RESET;
        end else if (wr_en && addr == DIVIDER_FIELD_ADDR) begin
            div_q <= wdata[DIV_FIELD_W-1:0];
        end else if (wr_en && addr == TIMEOUT_ADDR) begin
            to_q <= wdata;
        end
    end
    // Pulse spacing and run length counters; spacing restarts per interval
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            gap_q <= 4'h0;
            prev_q <= 1'b0;
            run_q <= 32'h0;
        end else begin
            gap_q <= st_clk_en ? 4'h1 : gap_q + 4'h1;
            prev_q <= core_isolate && !st_interval_start && (st_clk_en || prev_q);
            run_q <= (core_isolate && !cpu_reset) ? run_q + 32'h1 : 32'h0;
        end
    end
    AST_START_ISOLATES: assert property (start_wr && !core_isolate |=> core_isolate && st_interval_start)
        else $error("start did not isolate the core");
    AST_RESET_IN_ISOLATION: assert property (cpu_reset |-> core_isolate)
        else $error("cpu reset outside isolation");
    AST_NO_CLOCK_IDLE: assert property (!core_isolate |-> !st_clk_en)
        else $error("test clock outside a run");
    AST_RESET_LENGTH: assert property ($rose(cpu_reset) |-> cpu_reset [*8] ##1 !cpu_reset)
        else $error("cpu reset length wrong");
    AST_ISOLATE_RELEASE: assert property ($fell(core_isolate) |-> $fell(cpu_reset))
        else $error("isolation dropped without reset end");
    AST_CLOCK_SPACING: assert property (st_clk_en && prev_q && !st_interval_start |-> gap_q == divide)
        else $error("test clock spacing wrong");
    AST_TIMEOUT_BOUND: assert property (run_q <= to_q + 32'h3)
        else $error("run outlasted timeout");
    AST_INTERVAL_RANGE: assert property (st_interval <= 5'h19)
        else $error("interval index out of range");
    AST_READ_IDLE_ZERO: assert property (!$past(rd_en) |-> rdata == '0)
        else $error("read data outside answer cycle");
    AST_START_PULSE_RUN: assert property (st_interval_start |-> core_isolate)
        else $error("interval start outside run");
    COV_RESET: cover property ($rose(cpu_reset));
    COV_RESUME: cover property (st_interval_start && st_interval == 5'h01);
    COV_IRQ: cover property ($rose(irq));
endmodule

bind self_test_controller self_test_controller_props #(.SIG_W(SIG_W)) i_self_test_controller_props (
    .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .core_a_sig(core_a_sig), .core_b_sig(core_b_sig), .core_isolate(core_isolate), .st_clk_en(st_clk_en),
    .st_interval_start(st_interval_start), .st_interval(st_interval), .cpu_reset(cpu_reset), .irq(irq));

// [testbench/lockstep_core_model.sv]
// Behavioural pair of lockstep cores under test
module lockstep_core_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Test control from the controller
    input wire logic core_isolate,
    input wire logic st_clk_en,
    input wire logic [st_pkg::COUNT_W-1:0] st_interval,
    // Interval whose signatures diverge, 6'h3F for none
    input wire logic [5:0] fail_at,
    // Signatures
    output logic [31:0] core_a_sig,
    output logic [31:0] core_b_sig
);
    logic [31:0] sig_q;
    // Test activity only in isolation; outside it the lines churn
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sig_q <= 32'h0;
        end else if (!core_isolate) begin
            sig_q <= ~sig_q;
        end else if (st_clk_en) begin
            sig_q <= {sig_q[30:0], sig_q[31] ^ sig_q[21]} ^ {27'h0, st_interval};
        end
    end
    // Second core diverges only in the commanded interval
    assign core_a_sig = sig_q;
    assign core_b_sig = (fail_at == {1'b0, st_interval}) ? ~sig_q : sig_q;
endmodule

// [testbench/self_test_controller_tb.sv]
// Self-checking bench for the self-test controller
module self_test_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import st_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [5:0] fail_at = 6'h3F;
    logic [31:0] rdata, core_a_sig, core_b_sig;
    logic core_isolate, st_clk_en, st_interval_start, cpu_reset, irq;
    logic [4:0] st_interval;
    int errors = 0;
    int comparisons = 0;
    int pulses = 0;
`define CHK(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); end end
    always #10 ref_clk = ~ref_clk;
    self_test_controller i_self_test_controller (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .core_a_sig(core_a_sig), .core_b_sig(core_b_sig),
        .core_isolate(core_isolate), .st_clk_en(st_clk_en), .st_interval_start(st_interval_start),
        .st_interval(st_interval), .cpu_reset(cpu_reset), .irq(irq));
    lockstep_core_model i_lockstep_core_model (.ref_clk(ref_clk), .rstn(rstn), .core_isolate(core_isolate),
        .st_clk_en(st_clk_en), .st_interval(st_interval), .fail_at(fail_at), .core_a_sig(core_a_sig),
        .core_b_sig(core_b_sig));
    // Test clock pulses seen while a run holds isolation
    always @(posedge ref_clk) if (st_clk_en === 1'b1 && core_isolate === 1'b1) pulses++;
    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    // Data are taken in the single cycle after the strobe
    task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        `CHK(name, e, rdata & m)
    endtask
    // Start, retry start while busy (must be ignored), wait for release
    task automatic run(input logic [31:0] ctrl, input logic [4:0] first, input int exp_pulses);
        int n;
        pulses = 0;
        wr(CTRL_ADDR, ctrl);
        #1;
        `CHK("isolate", 1'b1, core_isolate)
        `CHK("first", first, st_interval)
        wr(CTRL_ADDR, 32'h00000103);
        n = 0;
        while (core_isolate === 1'b1 && n < 20000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK("run_end", 1'b0, core_isolate)
        if (exp_pulses >= 0) `CHK("pulses", exp_pulses, pulses)
    endtask
    task automatic post(input logic [31:0] m, input logic [31:0] e, input logic [2:0] ie);
        rd_chk("status", STATUS_ADDR, m, e);
        rd_chk("int_stat", INT_STAT_ADDR, 32'h7, {29'h0, ie});
        `CHK("irq", 1'b1, irq)
        wr(INT_STAT_ADDR, 32'h7);
        @(posedge ref_clk);
        #1;
        `CHK("irq_clear", 1'b0, irq)
    endtask
    // Span from the summed interval cycles at the slowest divide used
    initial begin
        repeat (40000) @(posedge ref_clk);
        errors++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd_chk("timeout_rst", TIMEOUT_ADDR, 32'hFFFFFFFF, TIMEOUT_RESET);
        rd_chk("divider_field_rst", DIVIDER_FIELD_ADDR, 32'h7, {29'h0, DIV_RESET});
        rd_chk("mask_rst", INT_MASK_ADDR, 32'hFFFFFFFF, 32'h0);
        wr(32'hFFFFE0F0, 32'hFFFFFFFF);
        rd_chk("unmapped", 32'hFFFFE0F0, 32'hFFFFFFFF, 32'h0);
        // Software setup: divide by two keeps the test clock under the limit
        wr(DIVIDER_FIELD_ADDR, 32'h1);
        wr(TIMEOUT_ADDR, 32'h8000);
        rd_chk("divider_field", DIVIDER_FIELD_ADDR, 32'h7, 32'h1);
        // One interval from the start, interrupt still masked
        run(32'h00000103, 5'h00, 1365);
        rd_chk("status1", STATUS_ADDR, 32'h1F0F, 32'h0102);
        rd_chk("exc", EXC_ADDR, 32'h20, 32'h20);
        wr(EXC_ADDR, 32'h20);
        rd_chk("exc_clr", EXC_ADDR, 32'h20, 32'h0);
        `CHK("irq_masked", 1'b0, irq)
        wr(INT_MASK_ADDR, 32'h7);
        post(32'h1F0F, 32'h0102, 3'b001);
        // Resume with two intervals from the second one
        run(32'h00000201, 5'h01, 2730);
        post(32'h1F0F, 32'h0302, 3'b001);
        // Restart at divide by three with a diverging signature in interval one
        fail_at <= 6'h01;
        wr(DIVIDER_FIELD_ADDR, 32'h2);
        run(32'h00000303, 5'h00, 2730);
        post(32'h1F0C, 32'h0204, 3'b010);
        rd_chk("fail_idx", FAIL_ADDR, 32'h1F, 32'h1);
        // Timeout long before the first interval can end
        fail_at <= 6'h3F;
        wr(TIMEOUT_ADDR, 32'h000001F4);
        run(32'h00000203, 5'h00, -1);
        post(32'h08, 32'h08, 3'b100);
        tally_and_finish;
    end
endmodule
